// ---- rsp_radio_port.sv ----
`timescale 1ns/1ns
`default_nettype none

// Contract
// [RULE1] 3-wire: one shared line, driven only for reads
// [RULE2] Master releases data line unless shifting out
// [RULE3] Master turns line around via swap bit
// [RULE4] Select low before transfer; ignore bus when high
// [RULE5] Muxed interrupt only while select is high
// [RULE6] Master releases data line while select high
// [RULE7] 4-wire: data in on MOSI, out on MISO
// [RULE8] Command byte first, then one or more data
// [RULE9] Command: direction, increment flag, 6-bit address
// [RULE10] Increment set: address steps after each byte
// [RULE11] Increment clear: fixed address, file pointer steps
// [RULE12] Port runs on serial clock only
// [RULE13] MISO and interrupt pins usable as GPIO
// [RULE14] Select, clock, MOSI shared with external slaves
// [RULE15] Interrupt polarity and open-drain programmable
// [RULE16] MSB first, sample rising, change other edge; the radio port shifts its read data on the rising edge
// [RULE17] Select high ends transaction, drops partial byte

module rsp_radio_port
    import rsp_pkg::*;
(
    // Reset and enable
    input wire logic rst_n,
    input wire logic clk_en,
    // Radio core side
    input wire logic irq_req,
    output logic [7:0] core_ctrl,
    // Serial link, clocked by the master's serial clock
    rsp_if.device lnk
);

    typedef struct packed {
        rsp_dphase_type phase;
        logic [2:0] bit_cnt;
        logic [6:0] shift_in;
        logic [5:0] addr;
        logic inc;
        logic [2:0] buf_ptr;
        logic [7:0] tx;
    } rsp_frame_type;

    typedef struct packed {
        logic [DEV_GEN_REGS-1:0][7:0] gen;
        logic [DEV_BUF_BYTES-1:0][7:0] fbuf;
        logic [7:0] port_cfg;
        logic [1:0] pin_meta;
        logic [1:0] pin_sync;
    } rsp_hold_type;

    rsp_frame_type fr;
    rsp_frame_type next_fr;
    rsp_hold_type hd;
    rsp_hold_type next_hd;
    logic frame_rst_n;
    logic reading;
    logic four_wire;
    logic serial_out;
    logic irq_level;
    logic irq_pin_val;
    logic irq_oe_n;
    logic turn_wait;

    // Read mux over the register space; holes read as zero
    function automatic logic [7:0] rd_byte(
        input rsp_hold_type h,
        input logic [5:0] a,
        input logic [2:0] p
    );
        logic [7:0] v;
        v = 8'h00;
        if (a <= DEV_ADDR_GEN_LAST) begin
            v = h.gen[a[2:0]];
        end else if (a == DEV_ADDR_PORT_CFG) begin
            v = h.port_cfg;
        end else if (a == DEV_ADDR_PIN_STAT) begin
            v = {6'h00, h.pin_sync}; // RULE13
        end else if (a == DEV_ADDR_BUF) begin
            v = h.fbuf[p]; // RULE11
        end
        return v;
    endfunction

    // Next state of the frame and the register space
    always_comb begin
        logic [7:0] byte_in;
        logic [5:0] a_next;
        logic [2:0] p_next;
        byte_in = {fr.shift_in, lnk.sdio};
        // Address and file pointer after a data byte
        a_next = fr.inc ? fr.addr + 6'h01 : fr.addr; // RULE10 RULE11
        p_next = (!fr.inc && fr.addr == DEV_ADDR_BUF)
            ? fr.buf_ptr + 3'h1 : fr.buf_ptr; // RULE11
        next_fr = fr;
        next_hd = hd;
        // GPIO pin levels, two stages
        next_hd.pin_meta = {lnk.irq, lnk.miso};
        next_hd.pin_sync = hd.pin_meta;
        // Sample on the rising edge, MSB first
        next_fr.bit_cnt = fr.bit_cnt + 3'h1; // RULE16
        next_fr.shift_in = byte_in[6:0];
        if (fr.phase == DPH_READ) begin
            next_fr.tx = {fr.tx[6:0], 1'b0}; // RULE16
        end
        if (fr.bit_cnt == 3'h7) begin
            case (fr.phase)
                DPH_CMD: begin
                    // Decode the command byte
                    next_fr.addr = byte_in[ADDR_W-1:0]; // RULE9
                    next_fr.inc = byte_in[CMD_INC_BIT]; // RULE9
                    next_fr.buf_ptr = 3'h0;
                    if (byte_in[CMD_DIR_BIT]) begin
                        next_fr.phase = DPH_WRITE; // RULE8 RULE9
                    end else begin
                        next_fr.phase = DPH_READ; // RULE8 RULE9
                        next_fr.tx = rd_byte(hd, byte_in[ADDR_W-1:0], 3'h0);
                    end
                end
                DPH_WRITE: begin
                    // Store a data byte; status is read-only
                    if (fr.addr <= DEV_ADDR_GEN_LAST) begin
                        next_hd.gen[fr.addr[2:0]] = byte_in;
                    end else if (fr.addr == DEV_ADDR_PORT_CFG) begin
                        next_hd.port_cfg = byte_in;
                    end else if (fr.addr == DEV_ADDR_BUF) begin
                        next_hd.fbuf[fr.buf_ptr] = byte_in; // RULE11
                    end
                    next_fr.addr = a_next; // RULE10
                    next_fr.buf_ptr = p_next;
                end
                DPH_READ: begin
                    // Fetch the following byte of the burst
                    next_fr.addr = a_next; // RULE10
                    next_fr.buf_ptr = p_next;
                    next_fr.tx = rd_byte(hd, a_next, p_next);
                end
                default: next_fr.phase = DPH_CMD;
            endcase
        end
    end

    // Frame state is cleared whenever select is high
    assign frame_rst_n = rst_n && !lnk.ss_n; // RULE4 RULE17

    // Frame register, on the serial clock only
    always_ff @(posedge lnk.sck or negedge frame_rst_n) begin // RULE12
        if (!frame_rst_n) begin
            fr <= '0; // RULE17
        end else if (clk_en) begin
            fr <= next_fr;
        end
    end

    // Register space, kept across frames
    always_ff @(posedge lnk.sck or negedge rst_n) begin // RULE12
        if (!rst_n) begin
            hd <= '0;
            hd.gen <= {DEV_GEN_REGS{DEV_REG_RESET}};
            hd.fbuf <= {DEV_BUF_BYTES{DEV_REG_RESET}};
            hd.port_cfg <= DEV_PORT_CFG_RESET;
        end else if (clk_en && !lnk.ss_n) begin
            hd <= next_hd; // RULE4
        end
    end

    // Pin drive decisions
    assign four_wire = hd.port_cfg[PCFG_FOUR_WIRE];
    assign reading = (fr.phase == DPH_READ) && !lnk.ss_n;
    assign serial_out = fr.tx[7];
    assign irq_level = hd.port_cfg[PCFG_IRQ_HIGH]
        ? irq_req : !irq_req; // RULE15
    // Master still drives until sck falls after a byte
    assign turn_wait = lnk.sck && (fr.bit_cnt == 3'h0); // RULE1
    assign irq_pin_val = hd.port_cfg[PCFG_IRQ_GPIO]
        ? hd.port_cfg[PCFG_IRQ_GPO] : irq_level; // RULE13
    assign irq_oe_n = hd.port_cfg[PCFG_IRQ_OD] ? irq_level : 1'b0; // RULE15

    // Dedicated interrupt pin
    assign lnk.d_irq_o = irq_pin_val;
    assign lnk.d_irq_oe_n = hd.port_cfg[PCFG_IRQ_GPIO]
        ? 1'b0 : irq_oe_n; // RULE13 RULE15

    // Separate return line for 4-wire mode
    assign lnk.d_miso_o = hd.port_cfg[PCFG_MISO_GPIO]
        ? hd.port_cfg[PCFG_MISO_GPO] : serial_out; // RULE13
    assign lnk.d_miso_oe_n = hd.port_cfg[PCFG_MISO_GPIO]
        ? 1'b0 : !(four_wire && reading); // RULE7

    // Shared data line: read data, or the interrupt while deselected
    always_comb begin
        lnk.d_sdio_o = 1'b1;
        lnk.d_sdio_oe_n = 1'b1;
        if (!lnk.ss_n) begin
            if (reading && !four_wire && !turn_wait) begin
                lnk.d_sdio_o = serial_out; // RULE1
                lnk.d_sdio_oe_n = 1'b0; // RULE1
            end
        end else if (hd.port_cfg[PCFG_IRQ_ON_SDIO]) begin
            lnk.d_sdio_o = irq_level; // RULE5
            lnk.d_sdio_oe_n = irq_oe_n; // RULE5 RULE15
        end
    end

    // Radio core control byte
    assign core_ctrl = hd.gen[0];

endmodule

`default_nettype wire

// ---- rsp_pkg.sv ----
`default_nettype none

package rsp_pkg;

    // Command byte layout
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_INC_BIT = 6;
    localparam int ADDR_W = 6;

    // Radio register map, reached over the serial link
    localparam logic [5:0] DEV_ADDR_GEN_LAST = 6'h07;
    localparam logic [5:0] DEV_ADDR_PORT_CFG = 6'h10;
    localparam logic [5:0] DEV_ADDR_PIN_STAT = 6'h11;
    localparam logic [5:0] DEV_ADDR_BUF = 6'h20;
    localparam int DEV_GEN_REGS = 8;
    localparam int DEV_BUF_BYTES = 8;
    localparam logic [7:0] DEV_PORT_CFG_RESET = 8'h00;
    localparam logic [7:0] DEV_REG_RESET = 8'h00;

    // Radio port configuration bits
    localparam int PCFG_IRQ_ON_SDIO = 0;
    localparam int PCFG_IRQ_HIGH = 1;
    localparam int PCFG_IRQ_OD = 2;
    localparam int PCFG_MISO_GPIO = 3;
    localparam int PCFG_IRQ_GPIO = 4;
    localparam int PCFG_MISO_GPO = 5;
    localparam int PCFG_IRQ_GPO = 6;
    localparam int PCFG_FOUR_WIRE = 7;

    // Master register map on the software port
    localparam logic [7:0] MST_ADDR_STATUS = 8'h3C;
    localparam logic [7:0] MST_ADDR_CFG = 8'h3D;
    localparam logic [7:0] MST_ADDR_SEL = 8'h3E;
    localparam logic [7:0] MST_ADDR_DATA = 8'h3F;
    localparam int MCFG_SWAP = 7;
    localparam int MCFG_FOUR_WIRE = 6;
    localparam int SEL_RADIO = 0;
    localparam int SEL_EXT = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SDIO = 1;
    localparam int STAT_IRQ = 2;
    localparam logic [7:0] MST_CFG_RESET = 8'h00;
    localparam logic [1:0] MST_SEL_RESET = 2'h0;

    // Serial clock timing
    localparam int CORE_PERIOD_NS = 10;
    localparam int SCK_HALF_NS = 40;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CORE_PERIOD_NS - 1)
        / CORE_PERIOD_NS;
    localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

    // Phases
    typedef enum logic [1:0] {DPH_CMD, DPH_WRITE, DPH_READ} rsp_dphase_type;
    typedef enum logic [1:0] {MPH_IDLE, MPH_LOW, MPH_HIGH} rsp_mphase_type;

endpackage

`default_nettype wire

// ---- rsp_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface rsp_if;
    // Clock and selects, driven by the master
    logic sck;
    logic ss_n;
    logic ext_ss_n;
    // Per-party drives of the shared lines
    logic m_sdio_o;
    logic m_sdio_oe_n;
    logic d_sdio_o;
    logic d_sdio_oe_n;
    logic d_miso_o;
    logic d_miso_oe_n;
    logic d_irq_o;
    logic d_irq_oe_n;
    // Resolved line levels, pulled up when undriven
    logic sdio;
    logic miso;
    logic irq;

    // Line resolution
    assign sdio = !m_sdio_oe_n ? m_sdio_o : (!d_sdio_oe_n ? d_sdio_o : 1'b1);
    assign miso = !d_miso_oe_n ? d_miso_o : 1'b1;
    assign irq = !d_irq_oe_n ? d_irq_o : 1'b1;

    modport master (
        output sck, ss_n, ext_ss_n, m_sdio_o, m_sdio_oe_n,
        input sdio, miso, irq
    );
    modport device (
        input sck, ss_n, sdio, miso, irq,
        output d_sdio_o, d_sdio_oe_n, d_miso_o, d_miso_oe_n,
        output d_irq_o, d_irq_oe_n
    );
endinterface

`default_nettype wire

// ---- rsp_master_port.sv ----
`timescale 1ns/1ns
`default_nettype none

module rsp_master_port
    import rsp_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Software register port
    input wire logic [7:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata,
    // Serial link
    rsp_if.master lnk
);

    typedef struct packed {
        rsp_mphase_type phase;
        logic [3:0] div;
        logic [2:0] bit_cnt;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] rdata;
        logic [7:0] cfg;
        logic [1:0] sel;
        logic sck;
        logic sdio_meta;
        logic sdio_sync;
        logic miso_meta;
        logic miso_sync;
        logic irq_meta;
        logic irq_sync;
    } rsp_mst_type;

    rsp_mst_type st;
    rsp_mst_type next_st;
    logic busy;
    logic in_bit;

    assign busy = (st.phase != MPH_IDLE);
    assign in_bit = st.cfg[MCFG_FOUR_WIRE]
        ? st.miso_sync : st.sdio_sync; // RULE7

    // Next state: pin synchronisers, registers, bit engine
    always_comb begin
        next_st = st;
        next_st.sdio_meta = lnk.sdio;
        next_st.sdio_sync = st.sdio_meta;
        next_st.miso_meta = lnk.miso;
        next_st.miso_sync = st.miso_meta;
        next_st.irq_meta = lnk.irq;
        next_st.irq_sync = st.irq_meta;
        next_st.rdata = 8'h00;
        if (sw_rd) begin
            case (sw_addr)
                MST_ADDR_STATUS: next_st.rdata = {5'h00, st.irq_sync,
                    st.sdio_sync, busy};
                MST_ADDR_CFG: next_st.rdata = st.cfg;
                MST_ADDR_SEL: next_st.rdata = {6'h00, st.sel};
                MST_ADDR_DATA: next_st.rdata = st.rx;
                default: next_st.rdata = 8'h00;
            endcase
        end
        if (sw_wr && sw_addr == MST_ADDR_CFG) begin
            next_st.cfg = sw_wdata; // RULE3
        end
        if (sw_wr && sw_addr == MST_ADDR_SEL) begin
            next_st.sel = sw_wdata[1:0]; // RULE4 RULE14
        end
        case (st.phase)
            MPH_IDLE: begin
                if (sw_wr && sw_addr == MST_ADDR_DATA) begin
                    next_st.tx = sw_wdata; // RULE8
                    next_st.bit_cnt = 3'h0;
                    next_st.div = 4'h0;
                    next_st.phase = MPH_LOW;
                end
            end
            MPH_LOW: begin
                next_st.div = st.div + 4'h1;
                if (st.div == SCK_HALF_LAST) begin
                    // Rising edge: sample the returning bit
                    next_st.div = 4'h0;
                    next_st.sck = 1'b1;
                    next_st.rx = {st.rx[6:0], in_bit}; // RULE16
                    next_st.phase = MPH_HIGH;
                end
            end
            MPH_HIGH: begin
                next_st.div = st.div + 4'h1;
                if (st.div == SCK_HALF_LAST) begin
                    // Falling edge: move to the next bit, MSB first
                    next_st.div = 4'h0;
                    next_st.sck = 1'b0;
                    next_st.tx = {st.tx[6:0], 1'b0}; // RULE16
                    next_st.bit_cnt = st.bit_cnt + 3'h1;
                    next_st.phase = (st.bit_cnt == 3'h7) ? MPH_IDLE : MPH_LOW;
                end
            end
            default: next_st.phase = MPH_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.cfg <= MST_CFG_RESET;
            st.sel <= MST_SEL_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Link pins; the data line is held until the last falling edge,
    // so the slave never samples a line that is being let go
    assign lnk.sck = st.sck;
    assign lnk.ss_n = !st.sel[SEL_RADIO];
    assign lnk.ext_ss_n = !st.sel[SEL_EXT];
    assign lnk.m_sdio_o = st.tx[7];
    assign lnk.m_sdio_oe_n = !(busy && (st.sel != 2'h0) // RULE2 RULE6
        && (st.cfg[MCFG_FOUR_WIRE] || !st.cfg[MCFG_SWAP])); // RULE3
    assign sw_rdata = st.rdata;

endmodule

`default_nettype wire

// ---- rsp_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none

module rsp_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link lines
    input wire logic sck,
    input wire logic ss_n,
    input wire logic ext_ss_n,
    input wire logic m_sdio_o,
    input wire logic m_sdio_oe_n,
    input wire logic d_sdio_oe_n,
    // Software read port
    input wire logic sw_rd,
    input wire logic [7:0] sw_rdata
);
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Serial clock half periods of four core cycles
    sequence s_high_half;
        sck [*4] ##1 !sck;
    endsequence
    sequence s_low_half;
        !sck [*4];
    endsequence

    // Never both ends on the shared line
    property p_one_driver;
        !(!m_sdio_oe_n && !d_sdio_oe_n);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("shared line driven by both ends");

    // Master lets go of the line with no select
    property p_master_release;
        ss_n && ext_ss_n |-> m_sdio_oe_n;
    endproperty
    a_master_release: assert property (p_master_release)
        else $error("master drives line while deselected");

    // Clock only runs under a select
    property p_sck_selected;
        $rose(sck) |-> !ss_n || !ext_ss_n;
    endproperty
    a_sck_selected: assert property (p_sck_selected)
        else $error("serial clock with no select");

    property p_select_steady;
        sck |-> $stable(ss_n);
    endproperty
    a_select_steady: assert property (p_select_steady)
        else $error("select moved while clock high");

    property p_high_half;
        $rose(sck) |-> s_high_half;
    endproperty
    a_high_half: assert property (p_high_half)
        else $error("clock high phase not four cycles");

    property p_low_half;
        $fell(sck) |-> s_low_half;
    endproperty
    a_low_half: assert property (p_low_half)
        else $error("clock low phase shorter than four cycles");

    // Outgoing bit holds while the slave samples it
    property p_mosi_steady;
        sck && $past(sck) && !m_sdio_oe_n && ($past(m_sdio_oe_n) == 1'b0)
            |-> $stable(m_sdio_o);
    endproperty
    a_mosi_steady: assert property (p_mosi_steady)
        else $error("outgoing bit changed while clock high");

    // Read data only in the cycle after a read strobe
    property p_rdata_idle;
        !$past(sw_rd) |-> sw_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
endmodule

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb
    import rsp_pkg::*;
    ;
    logic core_clk;
    logic rst_n;
    logic [7:0] sw_addr;
    logic [7:0] sw_wdata;
    logic sw_wr;
    logic sw_rd;
    logic [7:0] sw_rdata;
    logic irq_req;
    logic [7:0] core_ctrl;
    logic rd_seen;
    logic four;
    logic [7:0] mem_m [0:63];
    logic [7:0] fbuf [0:7];
    logic [7:0] wd [0:7];
    logic [7:0] opts [0:9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08,
        8'h28, 8'h10, 8'h50, 8'h03, 8'h01};
    logic [7:0] q [$];
    int mismatches;
    int cmp_count;
    int cycles;

    // Both ends joined over one link
    rsp_if lnk();
    rsp_master_port rsp_master_port_i (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(1'b1), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lnk(lnk));
    rsp_radio_port rsp_radio_port_i (.rst_n(rst_n), .clk_en(1'b1),
        .irq_req(irq_req), .core_ctrl(core_ctrl), .lnk(lnk));
    rsp_asserts rsp_asserts_i (.core_clk(core_clk), .rst_n(rst_n),
        .sck(lnk.sck), .ss_n(lnk.ss_n), .ext_ss_n(lnk.ext_ss_n),
        .m_sdio_o(lnk.m_sdio_o), .m_sdio_oe_n(lnk.m_sdio_oe_n),
        .d_sdio_oe_n(lnk.d_sdio_oe_n), .sw_rd(sw_rd), .sw_rdata(sw_rdata));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Software port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        q.push_back(e);
        @(posedge core_clk);
        sw_rd <= 1'b0;
    endtask

    // One byte on the link, busy lasts 64 cycles
    task automatic xfer(input logic [7:0] d);
        wr(MST_ADDR_DATA, d);
        repeat (66) @(posedge core_clk);
    endtask

    function automatic logic [7:0] dev_val(input logic [5:0] a,
        input logic [2:0] p);
        if (a == DEV_ADDR_BUF) return fbuf[p];
        if (a <= DEV_ADDR_GEN_LAST || a == DEV_ADDR_PORT_CFG) return mem_m[a];
        return 8'h00;
    endfunction

    // Command byte, then n data bytes, tracked in the model
    task automatic frame(input logic [7:0] cmd, input int n);
        logic [5:0] a;
        logic [2:0] p;
        a = cmd[5:0];
        p = 3'h0;
        wr(MST_ADDR_SEL, 8'h01);
        xfer(cmd);
        if (!cmd[CMD_DIR_BIT] && !four) begin
            wr(MST_ADDR_CFG, 8'h80);
        end
        for (int i = 0; i < n; i++) begin
            if (cmd[CMD_DIR_BIT] && a == DEV_ADDR_BUF) begin
                fbuf[p] = wd[i];
            end else if (cmd[CMD_DIR_BIT]) begin
                mem_m[a] = wd[i];
            end
            xfer(wd[i]);
            if (!cmd[CMD_DIR_BIT]) begin
                rd(MST_ADDR_DATA, dev_val(a, p));
            end
            if (cmd[CMD_INC_BIT]) begin
                a = a + 6'h01;
            end else if (a == DEV_ADDR_BUF) begin
                p = p + 3'h1;
            end
        end
        wr(MST_ADDR_SEL, 8'h00);
        wr(MST_ADDR_CFG, four ? 8'h40 : 8'h00);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Read data follows its strobe by one cycle
    always @(posedge core_clk) begin
        if (rd_seen) begin
            chk(sw_rdata, q.pop_front());
        end
        rd_seen <= sw_rd;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        logic [7:0] opt;
        logic lvl;
        rst_n = 1'b0;
        sw_addr = 8'h00;
        sw_wdata = 8'h00;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        irq_req = 1'b0;
        rd_seen = 1'b0;
        four = 1'b0;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        for (int i = 0; i < 64; i++) mem_m[i] = DEV_REG_RESET;
        mem_m[DEV_ADDR_PORT_CFG] = DEV_PORT_CFG_RESET;
        for (int i = 0; i < 8; i++) fbuf[i] = DEV_REG_RESET;
        void'($urandom(14));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        // Master registers after reset, unmapped place
        rd(MST_ADDR_CFG, MST_CFG_RESET);
        rd(MST_ADDR_SEL, {6'h00, MST_SEL_RESET});
        rd(MST_ADDR_STATUS, 8'h06);
        wr(8'h00, 8'hA5);
        rd(8'h00, 8'h00);
        wr(MST_ADDR_CFG, 8'h80);
        rd(MST_ADDR_CFG, 8'h80);
        wr(MST_ADDR_CFG, 8'h00);
        // Three-wire write burst at fixed address, read back
        for (int i = 0; i < 8; i++) wd[i] = 8'($urandom);
        frame(8'h85, 3);
        frame(8'h05, 2);
        // Bytes for the external slave leave the radio alone
        wr(MST_ADDR_SEL, 8'h02);
        xfer(8'h85);
        xfer(8'h3C);
        wr(MST_ADDR_SEL, 8'h00);
        frame(8'h05, 1);
        // Pin options against both request levels
        foreach (opts[k]) begin
            opt = opts[k];
            wd[0] = opt;
            frame(8'h90, 1);
            for (int r = 0; r < 2; r++) begin
                irq_req <= 1'(r);
                repeat (2) @(posedge core_clk);
                lvl = opt[1] ? irq_req : !irq_req;
                chk(lnk.miso, opt[3] ? opt[5] : 1'b1);
                if (!opt[0]) chk(lnk.irq, opt[4] ? opt[6] : lvl);
                if (!opt[4]) chk(lnk.d_irq_oe_n, opt[2] && lvl);
                chk(lnk.sdio, opt[0] ? lvl : 1'b1);
            end
        end
        // Request stays off the line while selected
        wr(MST_ADDR_CFG, 8'h80);
        wr(MST_ADDR_SEL, 8'h01);
        @(posedge core_clk);
        chk(lnk.sdio, 8'h01);
        wr(MST_ADDR_SEL, 8'h00);
        wr(MST_ADDR_CFG, 8'h00);
        // Four-wire mode on both ends
        wd[0] = 8'h80;
        frame(8'h90, 1);
        wr(MST_ADDR_CFG, 8'h40);
        four = 1'b1;
        for (int i = 0; i < 8; i++) wd[i] = 8'($urandom);
        frame(8'hC0, 8);
        chk(core_ctrl, mem_m[0]);
        frame(8'h40, 8);
        frame(8'hA0, 8);
        frame(8'h20, 8);
        frame(8'h08, 1);
        // Radio deselected after two bits of a byte
        wr(MST_ADDR_SEL, 8'h03);
        wr(MST_ADDR_DATA, 8'h86);
        rd(MST_ADDR_STATUS, 8'h03);
        repeat (14) @(posedge core_clk);
        wr(MST_ADDR_SEL, 8'h02);
        repeat (50) @(posedge core_clk);
        wr(MST_ADDR_SEL, 8'h00);
        frame(8'h06, 1);
        end_sim();
    end
endmodule

`default_nettype wire
